// ==== hdl/pmxh_regs.sv ====
// Register block: master window substitution and PCI configuration hook registers
`timescale 1ns/1ps
module pmxh_regs
    import pmxh_pkg::*;
#(
    parameter logic [31:0]          IDENT_RST = 32'h0000_0000  // Arbitrary neutral identity value
)
(
    input  wire logic                        I_MCLK,
    input  wire logic                        I_SRST,
    // APB slave
    input  wire logic                        I_PSEL,
    input  wire logic                        I_PENABLE,
    input  wire logic                        I_PWRITE,
    input  wire logic [PMXH_ADDR_W-1:0]      I_PADDR,
    input  wire logic [PMXH_DATA_W-1:0]      I_PWDATA,
    output logic      [PMXH_DATA_W-1:0]      O_PRDATA,
    output logic                             O_PREADY,
    output logic                             O_PSLVERR,
    // PCI side
    input  wire logic                        I_PCI_RST,
    input  wire logic                        I_EEPROM_AUTOINIT_SELECT,
    input  wire logic                        I_SETUP_COMPLETE,
    output pmxh_pkg::pmxh_live_t             O_LIVE_CFG,
    output logic                             O_PCI_ACCESS_HOLD,
    // Core reset
    output logic                             O_CORE_LOCAL_RESET,
    output logic                             O_CPU_RESET,
    // Master translation
    input  wire logic [PMXH_CPU_ADDR_W-1:0]  I_CPU_ADDR,
    input  wire logic                        I_CPU_VALID,
    output logic      [31:0]                 O_PCI_ADDR,
    output logic                             O_PCI_VALID
);

    // Elaboration-time checks on the map geometry
    if (PMXH_WIN_COUNT != (1 << PMXH_WIN_SEL_W)) begin
        $error("Window count must match the select width");
    end
    if (PMXH_SUBST_W + PMXH_SUBST_LSB != PMXH_DATA_W) begin
        $error("Substitution field must fill the top of the word");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [PMXH_WIN_COUNT*PMXH_SUBST_W-1:0] win;
        logic [31:0]        ident;
        logic               fast_clk;
        logic               cap_chain;
        logic [31:0]        class_rev;
        logic [31:0]        subsys;
        logic [15:0]        lat_gnt;
        logic               lrst;
        logic               cpu_rst;
        logic               hold;
        logic               pci_rst_seen;
        pmxh_live_t         live;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic [31:0]        pci_addr;
        logic               pci_valid;
    } pmxh_state_t;

    pmxh_state_t        st;
    pmxh_state_t        next_st;
    pmxh_xlate_if       xl ();

    logic               acc;
    logic               wr;
    logic               win_hit;
    logic [PMXH_WIN_SEL_W-1:0] win_idx;
    logic [31:0]        rd;
    logic               hit;

    assign xl.table_bits = st.win;
    assign xl.cpu_addr   = I_CPU_ADDR;
    assign xl.cpu_valid  = I_CPU_VALID;

    pmxh_xlate u_xlate (
        .I_MCLK (I_MCLK),
        .I_SRST (I_SRST),
        .x      (xl)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        // Setup phase only: answer lands in the access phase, zero wait states
        acc     = I_PSEL && !I_PENABLE;
        wr      = acc && I_PWRITE;
        win_hit = (I_PADDR >= PMXH_OFS_WIN_BASE) && (I_PADDR <= PMXH_OFS_WIN_LAST) && (I_PADDR[1:0] == 2'b00);
        win_idx = I_PADDR[PMXH_WIN_SEL_W+1:2];
        rd      = PMXH_ZERO_WORD;
        hit     = 1'b1;

        if (win_hit) begin
            rd[PMXH_DATA_W-1 -: PMXH_SUBST_W] = st.win[win_idx*PMXH_SUBST_W +: PMXH_SUBST_W];
        end else begin
            case (I_PADDR)
                PMXH_OFS_IDENT: begin
                    rd = st.ident;
                end
                PMXH_OFS_CMDSTAT: begin
                    rd[PMXH_FAST_CLK_BIT]  = st.fast_clk;
                    rd[PMXH_CAP_CHAIN_BIT] = st.cap_chain;
                end
                PMXH_OFS_CLASSREV: begin
                    rd = st.class_rev;
                end
                PMXH_OFS_SUBSYS: begin
                    rd = st.subsys;
                end
                PMXH_OFS_LATGNT: begin
                    rd[PMXH_LATGNT_W-1:0] = st.lat_gnt;
                end
                PMXH_OFS_LRST: begin
                    rd[PMXH_LRST_BIT] = st.lrst;
                end
                PMXH_OFS_STATUS: begin
                    rd[PMXH_ST_LRST_BIT]   = st.cpu_rst;
                    rd[PMXH_ST_DONE_BIT]   = I_SETUP_COMPLETE;
                    rd[PMXH_ST_HOLD_BIT]   = st.hold;
                    rd[PMXH_ST_PCIRST_BIT] = st.pci_rst_seen;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end

        next_st.pready  = acc;
        next_st.pslverr = acc && !hit;
        if (acc) begin
            next_st.prdata = I_PWRITE ? PMXH_ZERO_WORD : rd;
        end

        if (wr && win_hit) begin
            next_st.win[win_idx*PMXH_SUBST_W +: PMXH_SUBST_W] = I_PWDATA[PMXH_DATA_W-1 -: PMXH_SUBST_W];
        end
        if (wr && !win_hit) begin
            case (I_PADDR)
                PMXH_OFS_IDENT: begin
                    next_st.ident = I_PWDATA;
                end
                PMXH_OFS_CMDSTAT: begin
                    next_st.fast_clk  = I_PWDATA[PMXH_FAST_CLK_BIT];
                    next_st.cap_chain = I_PWDATA[PMXH_CAP_CHAIN_BIT];
                end
                PMXH_OFS_CLASSREV: begin
                    next_st.class_rev = I_PWDATA;
                end
                PMXH_OFS_SUBSYS: begin
                    next_st.subsys = I_PWDATA;
                end
                PMXH_OFS_LATGNT: begin
                    next_st.lat_gnt = I_PWDATA[PMXH_LATGNT_W-1:0];
                end
                PMXH_OFS_LRST: begin
                    next_st.lrst = I_PWDATA[PMXH_LRST_BIT];
                end
                default: begin
                end
            endcase
        end

        // Processor reset follows the local reset it is derived from
        next_st.cpu_rst = next_st.lrst;

        // Copy uses the hook values as they stand, so a write in the same cycle is copied only if the PCI reset is still high the next cycle
        if (I_PCI_RST) begin
            next_st.live.ident                    = st.ident;
            next_st.live.fast_clock_capable       = st.fast_clk;
            next_st.live.capability_chain_present = st.cap_chain;
            next_st.live.class_rev                = st.class_rev;
            next_st.live.subsys                   = st.subsys;
            next_st.live.lat_gnt                  = st.lat_gnt;
            next_st.pci_rst_seen                  = 1'b1;
        end

        next_st.hold = I_EEPROM_AUTOINIT_SELECT && !I_SETUP_COMPLETE;

        next_st.pci_addr  = xl.pci_addr;
        next_st.pci_valid = xl.pci_valid;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            st                 <= '0;
            st.win             <= {PMXH_WIN_COUNT{PMXH_SUBST_RST}};
            st.ident           <= IDENT_RST;
            st.fast_clk        <= PMXH_FAST_CLK_RST;
            st.cap_chain       <= PMXH_CAP_CHAIN_RST;
            st.class_rev       <= PMXH_CLASSREV_RST;
            st.subsys          <= PMXH_SUBSYS_RST;
            st.lat_gnt         <= PMXH_LATGNT_RST;
            st.lrst            <= PMXH_LRST_RST;
            st.cpu_rst         <= PMXH_LRST_RST;
            // Hold from reset until the strap is seen the next cycle; errs on the safe side
            st.hold            <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign O_PRDATA           = st.prdata;
    assign O_PREADY           = st.pready;
    assign O_PSLVERR          = st.pslverr;
    assign O_LIVE_CFG         = st.live;
    assign O_PCI_ACCESS_HOLD  = st.hold;
    assign O_CORE_LOCAL_RESET = st.lrst;
    assign O_CPU_RESET        = st.cpu_rst;
    assign O_PCI_ADDR         = st.pci_addr;
    assign O_PCI_VALID        = st.pci_valid;

endmodule

// ==== hdl/pmxh_pkg.sv ====
// Package for the master window translation and configuration hook register block
package pmxh_pkg;

    // ****************************************************************
    // Bus and map geometry
    // ****************************************************************
    localparam int                  PMXH_DATA_W        = 32;
    localparam int                  PMXH_ADDR_W        = 12;
    localparam int                  PMXH_WIN_COUNT     = 32;
    localparam int                  PMXH_WIN_SEL_W     = 5;
    localparam int                  PMXH_SUBST_W       = 9;
    localparam int                  PMXH_SUBST_LSB     = 23;
    localparam int                  PMXH_CPU_ADDR_W    = 28;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0]         PMXH_OFS_WIN_BASE  = 12'h000;
    localparam logic [11:0]         PMXH_OFS_WIN_LAST  = 12'h07c;
    localparam logic [11:0]         PMXH_OFS_IDENT     = 12'h100;
    localparam logic [11:0]         PMXH_OFS_CMDSTAT   = 12'h104;
    localparam logic [11:0]         PMXH_OFS_CLASSREV  = 12'h108;
    localparam logic [11:0]         PMXH_OFS_SUBSYS    = 12'h10c;
    localparam logic [11:0]         PMXH_OFS_LATGNT    = 12'h110;
    localparam logic [11:0]         PMXH_OFS_LRST      = 12'h114;
    localparam logic [11:0]         PMXH_OFS_STATUS    = 12'h118;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int                  PMXH_FAST_CLK_BIT  = 1;
    localparam int                  PMXH_CAP_CHAIN_BIT = 0;
    localparam int                  PMXH_LRST_BIT      = 0;
    localparam int                  PMXH_LATGNT_W      = 16;
    localparam int                  PMXH_ST_LRST_BIT   = 0;
    localparam int                  PMXH_ST_DONE_BIT   = 1;
    localparam int                  PMXH_ST_HOLD_BIT   = 2;
    localparam int                  PMXH_ST_PCIRST_BIT = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [8:0]          PMXH_SUBST_RST     = 9'h000;
    // Arbitrary neutral class/revision default, not any real device code
    localparam logic [31:0]         PMXH_CLASSREV_RST  = 32'h00c3_0000;
    localparam logic [31:0]         PMXH_SUBSYS_RST    = 32'h0000_0000;
    localparam logic [15:0]         PMXH_LATGNT_RST    = 16'h0000;
    localparam logic                PMXH_CAP_CHAIN_RST = 1'b0;
    // Fast-clock default has no defined reset level; zero chosen for determinism
    localparam logic                PMXH_FAST_CLK_RST  = 1'b0;
    localparam logic                PMXH_LRST_RST      = 1'b0;
    localparam logic [31:0]         PMXH_ZERO_WORD     = 32'h0000_0000;

    // Live configuration words latched on the PCI reset
    typedef struct packed {
        logic [31:0]                ident;
        logic                       fast_clock_capable;
        logic                       capability_chain_present;
        logic [31:0]                class_rev;
        logic [31:0]                subsys;
        logic [15:0]                lat_gnt;
    } pmxh_live_t;

endpackage

// ==== hdl/pmxh_xlate_if.sv ====
// Interface carrying translation requests between the register core and the translator
`timescale 1ns/1ps
interface pmxh_xlate_if;
    logic [pmxh_pkg::PMXH_WIN_COUNT*pmxh_pkg::PMXH_SUBST_W-1:0] table_bits;
    logic [pmxh_pkg::PMXH_CPU_ADDR_W-1:0]                       cpu_addr;
    logic                                                        cpu_valid;
    logic [31:0]                                                 pci_addr;
    logic                                                        pci_valid;

    modport regs (output table_bits, output cpu_addr, output cpu_valid, input pci_addr, input pci_valid);
    modport xlate (input table_bits, input cpu_addr, input cpu_valid, output pci_addr, output pci_valid);
endinterface

// ==== hdl/pmxh_xlate.sv ====
// Master window translator: picks a substitution field and forms the PCI address
`timescale 1ns/1ps
module pmxh_xlate
    import pmxh_pkg::*;
(
    input  wire logic   I_MCLK,
    input  wire logic   I_SRST,
    pmxh_xlate_if.xlate x
);

    typedef struct packed {
        logic [31:0]    pci_addr;
        logic           pci_valid;
    } pmxh_xl_state_t;

    pmxh_xl_state_t     st;
    pmxh_xl_state_t     next_st;
    logic [PMXH_WIN_SEL_W-1:0] sel;

    always_comb begin
        next_st = st;
        // Top five of the 28 CPU bits choose one of 32 eight-megabyte windows
        sel = x.cpu_addr[PMXH_CPU_ADDR_W-1 -: PMXH_WIN_SEL_W];
        next_st.pci_valid = x.cpu_valid;
        if (x.cpu_valid) begin
            next_st.pci_addr = {x.table_bits[sel*PMXH_SUBST_W +: PMXH_SUBST_W],
                                x.cpu_addr[PMXH_SUBST_LSB-1:0]};
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign x.pci_addr  = st.pci_addr;
    assign x.pci_valid = st.pci_valid;

endmodule

// ==== tb/pmxh_regs_monitor.sv ====
// Concurrent checks on the register block ports
`timescale 1ns/1ps
module pmxh_regs_monitor
    import pmxh_pkg::*;
(
    input wire logic        I_MCLK,
    input wire logic        I_SRST,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic        I_PCI_RST,
    input wire logic        I_EEPROM_AUTOINIT_SELECT,
    input wire logic        I_SETUP_COMPLETE,
    input wire pmxh_live_t  O_LIVE_CFG,
    input wire logic        O_PCI_ACCESS_HOLD,
    input wire logic        O_CORE_LOCAL_RESET,
    input wire logic        O_CPU_RESET,
    input wire logic [27:0] I_CPU_ADDR,
    input wire logic        I_CPU_VALID,
    input wire logic [31:0] O_PCI_ADDR,
    input wire logic        O_PCI_VALID
);
    logic        mapped;
    logic        hold_cause;
    logic [22:0] low_a;
    assign mapped = (I_PADDR[1:0] == 2'b00)
                 && (I_PADDR <= PMXH_OFS_WIN_LAST || (I_PADDR >= PMXH_OFS_IDENT && I_PADDR <= PMXH_OFS_STATUS));
    assign hold_cause = I_EEPROM_AUTOINIT_SELECT && !I_SETUP_COMPLETE;
    assign low_a = I_CPU_ADDR[22:0];
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_SRST);
    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_lrst_wr;
        s_setup ##0 (I_PWRITE && I_PADDR == PMXH_OFS_LRST);
    endsequence
    sequence s_win_rd;
        s_setup ##0 (!I_PWRITE && I_PADDR <= PMXH_OFS_WIN_LAST);
    endsequence
    a_ready_next: assert property (s_setup |=> O_PREADY) else $error("no ready after setup");
    a_ready_cause: assert property (O_PREADY |-> $past(I_PSEL) && !$past(I_PENABLE))
        else $error("ready without setup");
    a_err_unmapped: assert property (s_setup |=> O_PSLVERR == !$past(mapped))
        else $error("error flag does not match decode");
    a_err_data_zero: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == PMXH_ZERO_WORD)
        else $error("error answer not clean");
    a_win_reserved: assert property (s_win_rd |=> O_PRDATA[22:0] == 23'h0)
        else $error("window low bits not zero");
    a_lrst_write: assert property (s_lrst_wr |=> O_CORE_LOCAL_RESET == $past(I_PWDATA[0]))
        else $error("local reset bit not written");
    a_cpu_held: assert property (O_CPU_RESET == O_CORE_LOCAL_RESET) else $error("cpu reset differs");
    a_xlate_valid: assert property (I_CPU_VALID |-> ##2 O_PCI_VALID) else $error("translation lost");
    a_xlate_low: assert property (O_PCI_VALID |-> $past(I_CPU_VALID, 2) && O_PCI_ADDR[22:0] == $past(low_a, 2))
        else $error("translated low bits wrong");
    a_live_frozen: assert property (!I_PCI_RST |=> $stable(O_LIVE_CFG))
        else $error("live config moved without bus reset");
    a_hold_follow: assert property (!$past(I_SRST) |-> O_PCI_ACCESS_HOLD == $past(hold_cause))
        else $error("access hold wrong");
endmodule
bind pmxh_regs pmxh_regs_monitor u_mon (.I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_PCI_RST(I_PCI_RST),
    .I_EEPROM_AUTOINIT_SELECT(I_EEPROM_AUTOINIT_SELECT), .I_SETUP_COMPLETE(I_SETUP_COMPLETE),
    .O_LIVE_CFG(O_LIVE_CFG), .O_PCI_ACCESS_HOLD(O_PCI_ACCESS_HOLD), .O_CORE_LOCAL_RESET(O_CORE_LOCAL_RESET),
    .O_CPU_RESET(O_CPU_RESET), .I_CPU_ADDR(I_CPU_ADDR), .I_CPU_VALID(I_CPU_VALID), .O_PCI_ADDR(O_PCI_ADDR),
    .O_PCI_VALID(O_PCI_VALID));

// ==== tb/pmxh_pci_host.sv ====
// PCI-side agent model: bus reset pulses, boot strap and configuration-done flag
`timescale 1ns/1ps
module pmxh_pci_host (
    input  wire logic i_clk,
    output logic      o_pci_rst,
    output logic      o_autoinit,
    output logic      o_done
);
    // Boot with autoinit selected and configuration not yet done
    initial begin
        o_pci_rst = 1'b0;
        o_autoinit = 1'b1;
        o_done = 1'b0;
    end
    task automatic pulse_reset(input int n);
        @(posedge i_clk);
        o_pci_rst <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_pci_rst <= 1'b0;
    endtask
    // Done is driven to whatever level the caller gives, at the next clock edge
    task automatic strap(input logic ee, input logic dn);
        @(posedge i_clk);
        o_autoinit <= ee;
        o_done <= dn;
    endtask
endmodule

// ==== tb/pmxh_regs_tb.sv ====
// Self-checking bench for the window translation and hook register block
`timescale 1ns/1ps
module pmxh_regs_tb;
    import pmxh_pkg::*;
    localparam logic [31:0] IDENT_V = 32'h5a5a_3c3c; // Arbitrary identity value
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic        cval = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [27:0] caddr = 28'h0;
    logic [31:0] prdata, pci_addr;
    logic        pready, pslverr, pci_val, lrst, cpurst, hold, pci_rst, ee, done;
    pmxh_live_t  live;
    logic [31:0] mdl [logic [11:0]];
    logic [31:0] exq [$];
    int          num_errors = 0;
    int          tests_run = 0;

    always #25 clk = ~clk;

    pmxh_regs #(.IDENT_RST(IDENT_V)) uut (.I_MCLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_PCI_RST(pci_rst), .I_EEPROM_AUTOINIT_SELECT(ee), .I_SETUP_COMPLETE(done),
        .O_LIVE_CFG(live), .O_PCI_ACCESS_HOLD(hold), .O_CORE_LOCAL_RESET(lrst), .O_CPU_RESET(cpurst),
        .I_CPU_ADDR(caddr), .I_CPU_VALID(cval), .O_PCI_ADDR(pci_addr), .O_PCI_VALID(pci_val));
    pmxh_pci_host u_pci (.i_clk(clk), .o_pci_rst(pci_rst), .o_autoinit(ee), .o_done(done));

    task automatic conclude();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_live(input pmxh_live_t got, input pmxh_live_t exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ****
    // Register bus master and register model
    // ****
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            conclude();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    function automatic logic [31:0] wmask(input logic [11:0] a);
        if (a < 12'h080) return 32'hff80_0000;
        case (a)
            PMXH_OFS_CMDSTAT: return 32'h0000_0003;
            PMXH_OFS_LATGNT: return 32'h0000_ffff;
            PMXH_OFS_LRST: return 32'h0000_0001;
            default: return 32'hffff_ffff;
        endcase
    endfunction
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        logic        hit;
        hit = mdl.exists(a);
        apb(wr, a, d, rd, err);
        chk_w({31'h0, err}, {31'h0, !hit});
        if (wr && hit) mdl[a] = d & wmask(a);
        if (!wr) chk_w(rd, hit ? mdl[a] : 32'h0);
    endtask
    function automatic pmxh_live_t live_exp();
        return '{mdl[PMXH_OFS_IDENT], mdl[PMXH_OFS_CMDSTAT][1], mdl[PMXH_OFS_CMDSTAT][0],
                 mdl[PMXH_OFS_CLASSREV], mdl[PMXH_OFS_SUBSYS], mdl[PMXH_OFS_LATGNT][15:0]};
    endfunction

    // Translations come back in request order, so a queue pairs them
    always @(posedge clk) begin
        if (pci_val === 1'b1) begin
            if (exq.size() == 0) chk_w({31'h0, pci_val}, 32'h0);
            else chk_w(pci_addr, exq.pop_front());
        end
    end

    initial begin
        logic [27:0] ca;
        logic        v;
        pmxh_live_t  old;
        void'($urandom(32'h35d6));
        for (int i = 0; i < 32; i++) mdl[12'(i * 4)] = 32'h0;
        mdl[PMXH_OFS_IDENT] = IDENT_V;
        mdl[PMXH_OFS_CMDSTAT] = 32'h0;
        mdl[PMXH_OFS_CLASSREV] = PMXH_CLASSREV_RST;
        mdl[PMXH_OFS_SUBSYS] = 32'h0;
        mdl[PMXH_OFS_LATGNT] = 32'h0;
        mdl[PMXH_OFS_LRST] = 32'h0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        foreach (mdl[a]) xfer(1'b0, a, 32'h0);
        foreach (mdl[a]) xfer(1'b1, a, $urandom());
        xfer(1'b1, 12'h200, $urandom());
        xfer(1'b0, 12'h200, 32'h0);
        foreach (mdl[a]) xfer(1'b0, a, 32'h0);
        chk_live(live, '0);
        u_pci.pulse_reset(2);
        repeat (2) @(posedge clk);
        chk_live(live, live_exp());
        old = live_exp();
        xfer(1'b1, PMXH_OFS_IDENT, ~mdl[PMXH_OFS_IDENT]);
        xfer(1'b1, PMXH_OFS_CMDSTAT, ~mdl[PMXH_OFS_CMDSTAT]);
        chk_live(live, old);
        u_pci.pulse_reset(1);
        repeat (2) @(posedge clk);
        chk_live(live, live_exp());
        for (int k = 1; k >= 0; k--) begin
            xfer(1'b1, PMXH_OFS_LRST, 32'(k));
            chk_w({31'h0, lrst}, 32'(k));
            chk_w({31'h0, cpurst}, 32'(k));
        end
        for (int k = 0; k < 4; k++) begin
            u_pci.strap(k[1], k[0]);
            repeat (3) @(posedge clk);
            chk_w({31'h0, hold}, {31'h0, k[1] & ~k[0]});
        end
        // Status: core out of reset, setup complete, no hold, bus reset seen
        mdl[PMXH_OFS_STATUS] = 32'((1 << PMXH_ST_PCIRST_BIT) | (1 << PMXH_ST_DONE_BIT));
        xfer(1'b0, PMXH_OFS_STATUS, 32'h0);
        // Back-to-back requests with random gaps across randomly chosen windows
        repeat (80) begin
            ca = 28'($urandom());
            v = 1'($urandom());
            @(posedge clk);
            cval <= v;
            caddr <= ca;
            if (v) exq.push_back({mdl[12'({ca[27:23], 2'b00})][31:23], ca[22:0]});
        end
        @(posedge clk);
        cval <= 1'b0;
        repeat (4) @(posedge clk);
        chk_w(32'(exq.size()), 32'h0);
        conclude();
    end
endmodule
